// File: include/asa_pkg.sv
// Package for the alarm status aggregator: offsets, reset values, bit positions
package asa_pkg;

  // ==========================================================================
  // Register bus geometry
  localparam int ASA_ADDR_W = 4;
  localparam int ASA_DATA_W = 16;

  // ==========================================================================
  // Register offsets
  localparam logic [3:0] ASA_OFF_ALARM_STATUS = 4'h0; // Sticky status, write one to clear
  localparam logic [3:0] ASA_OFF_RAW_STATUS = 4'h1; // Raw alarm status, read only
  localparam logic [3:0] ASA_OFF_ALARM_ENABLE = 4'h2; // Live alarm enable
  localparam logic [3:0] ASA_OFF_DEFAULT_MASK = 4'h3; // Default alarm enable mask
  localparam logic [3:0] ASA_OFF_SF_MASK_AB = 4'h4; // Safety alert masks first/second
  localparam logic [3:0] ASA_OFF_SF_MASK_C = 4'h5; // Safety alert mask third
  localparam logic [3:0] ASA_OFF_PF_MASK_AB = 4'h6; // Permanent alert masks first/second
  localparam logic [3:0] ASA_OFF_PF_MASK_CD = 4'h7; // Permanent alert masks third/fourth
  localparam logic [3:0] ASA_OFF_IRQ_MASK = 4'h8; // Interrupt mask
  localparam logic [3:0] ASA_OFF_CONTROL = 4'h9; // Configuration update mode

  // ==========================================================================
  // Reset values
  localparam logic [15:0] ASA_DEFAULT_MASK_RST = 16'hF800;
  localparam logic [7:0] ASA_SF_MASK_A_RST = 8'hFC;
  localparam logic [7:0] ASA_SF_MASK_B_RST = 8'hF7;
  localparam logic [7:0] ASA_SF_MASK_C_RST = 8'hF4;
  localparam logic [7:0] ASA_PF_MASK_A_RST = 8'h5F;
  localparam logic [7:0] ASA_PF_MASK_B_RST = 8'h9F;
  localparam logic [7:0] ASA_PF_MASK_C_RST = 8'h00;
  localparam logic [7:0] ASA_PF_MASK_D_RST = 8'h00;
  localparam logic [15:0] ASA_IRQ_MASK_RST = 16'h0000;
  localparam logic [15:0] ASA_ZERO16 = 16'h0000;
  localparam logic [7:0] ASA_ZERO8 = 8'h00;

  // ==========================================================================
  // Alarm bit positions
  localparam int ASA_B_SAFETY_STATUS_SECOND_THIRD_FLAG = 15;
  localparam int ASA_B_SSA = 14;
  localparam int ASA_B_PF = 13;
  localparam int ASA_B_MSF = 12;
  localparam int ASA_B_MPF = 11;
  localparam int ASA_B_INITB = 10;
  localparam int ASA_B_INITD = 9;
  localparam int ASA_B_RSVD = 8;
  localparam int ASA_B_FULL = 7;
  localparam int ASA_B_CHARGE_SWITCH_OFF_FLAG = 6;
  localparam int ASA_B_DISCHARGE_SWITCH_OFF_FLAG = 5;
  localparam int ASA_B_SHUT = 4;
  localparam int ASA_B_FUSE = 3;
  localparam int ASA_B_CB = 2;
  localparam int ASA_B_SCAN = 1;
  localparam int ASA_B_WAKE = 0;
  localparam int ASA_B_CFG = 0; // Control register: configuration update mode

  // ==========================================================================
  // Init sequencer states
  typedef enum logic [1:0] {
    ASA_INIT_IDLE = 2'b00,
    ASA_INIT_BEGUN = 2'b01,
    ASA_INIT_DONE = 2'b10
  } asa_init_type;

endpackage : asa_pkg

// File: rtl/asa_alarm_status_aggregator.sv
// Alarm status aggregator: raw alarm word, enables, sticky status and interrupt
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module asa_alarm_status_aggregator (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [asa_pkg::ASA_ADDR_W-1:0] reg_addr,
  input wire logic [asa_pkg::ASA_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [asa_pkg::ASA_DATA_W-1:0] reg_rdata,
  // Safety status and alert words
  input wire logic [7:0] safety_status_first,
  input wire logic [7:0] safety_status_second,
  input wire logic [7:0] safety_status_third,
  input wire logic [7:0] safety_alert_word_first,
  input wire logic [7:0] safety_alert_word_second,
  input wire logic [7:0] safety_alert_word_third,
  // Permanent failure words
  input wire logic permanent_fault_triggered,
  input wire logic [7:0] pf_alert_word_first,
  input wire logic [7:0] pf_alert_word_second,
  input wire logic [7:0] pf_alert_word_third,
  input wire logic [7:0] pf_alert_word_fourth,
  // Measurement and power events
  input wire logic single_scan_done,
  input wire logic full_loop_done,
  input wire logic wake_event,
  // Level conditions
  input wire logic charge_switch_off,
  input wire logic discharge_switch_off,
  input wire logic stack_below_shutdown,
  input wire logic fuse_driven,
  input wire logic balancing_active,
  // Results
  output logic [asa_pkg::ASA_DATA_W-1:0] alarm_status,
  output logic config_update_mode,
  output logic irq
);
  import asa_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0] default_mask;
    logic [15:0] alarm_enable;
    logic [7:0] sf_mask_a;
    logic [7:0] sf_mask_b;
    logic [7:0] sf_mask_c;
    logic [7:0] pf_mask_a;
    logic [7:0] pf_mask_b;
    logic [7:0] pf_mask_c;
    logic [7:0] pf_mask_d;
    logic [15:0] irq_mask;
    logic [15:0] sticky;
    logic [15:0] raw_events;
    logic cfg_mode;
    asa_init_type init;
    logic [15:0] rdata;
  } asa_state_type;

  asa_state_type state_q;
  asa_state_type state_d;
  logic [15:0] raw_word;

  // Nonzero test of a masked byte
  function automatic logic asa_hit(input logic [7:0] word, input logic [7:0] mask);
    asa_hit = |(word & mask);
  endfunction : asa_hit

  // ==========================================================================
  // Raw alarm word: levels live, event bits latched until cleared
  always_comb begin
    raw_word = ASA_ZERO16;
    raw_word[ASA_B_SAFETY_STATUS_SECOND_THIRD_FLAG] = |{safety_status_second, safety_status_third};
    raw_word[ASA_B_SSA] = |safety_status_first;
    raw_word[ASA_B_PF] = state_q.raw_events[ASA_B_PF];
    raw_word[ASA_B_MSF] = asa_hit(safety_alert_word_first, state_q.sf_mask_a) |
                          asa_hit(safety_alert_word_second, state_q.sf_mask_b) |
                          asa_hit(safety_alert_word_third, state_q.sf_mask_c);
    raw_word[ASA_B_MPF] = asa_hit(pf_alert_word_first, state_q.pf_mask_a) |
                          asa_hit(pf_alert_word_second, state_q.pf_mask_b) |
                          asa_hit(pf_alert_word_third, state_q.pf_mask_c) |
                          asa_hit(pf_alert_word_fourth, state_q.pf_mask_d);
    raw_word[ASA_B_INITB] = state_q.raw_events[ASA_B_INITB];
    raw_word[ASA_B_INITD] = state_q.raw_events[ASA_B_INITD];
    raw_word[ASA_B_FULL] = state_q.raw_events[ASA_B_FULL];
    raw_word[ASA_B_CHARGE_SWITCH_OFF_FLAG] = charge_switch_off;
    raw_word[ASA_B_DISCHARGE_SWITCH_OFF_FLAG] = discharge_switch_off;
    raw_word[ASA_B_SHUT] = stack_below_shutdown;
    raw_word[ASA_B_FUSE] = fuse_driven;
    raw_word[ASA_B_CB] = balancing_active;
    raw_word[ASA_B_SCAN] = state_q.raw_events[ASA_B_SCAN];
    raw_word[ASA_B_WAKE] = state_q.raw_events[ASA_B_WAKE];
    raw_word[ASA_B_RSVD] = 1'b0;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    logic [15:0] ev;
    logic [15:0] clr;
    logic [15:0] rd_val;
    ev = ASA_ZERO16;
    clr = ASA_ZERO16;
    rd_val = ASA_ZERO16;
    state_d = state_q;
    // Event pulses into the raw word
    ev[ASA_B_PF] = permanent_fault_triggered;
    ev[ASA_B_FULL] = full_loop_done;
    ev[ASA_B_SCAN] = single_scan_done;
    ev[ASA_B_WAKE] = wake_event;
    // Init sequence: begun after reset, done after first scan
    case (state_q.init)
      ASA_INIT_IDLE: begin
        ev[ASA_B_INITB] = 1'b1;
        state_d.init = ASA_INIT_BEGUN;
      end
      ASA_INIT_BEGUN: begin
        if (single_scan_done) begin
          ev[ASA_B_INITD] = 1'b1;
          state_d.init = ASA_INIT_DONE;
        end
      end
      default: begin
        state_d.init = ASA_INIT_DONE;
      end
    endcase
    // Register writes
    if (reg_wr) begin
      if (reg_addr == ASA_OFF_ALARM_STATUS) begin
        clr = reg_wdata;
      end else if (reg_addr == ASA_OFF_ALARM_ENABLE) begin
        state_d.alarm_enable = reg_wdata;
      end else if (reg_addr == ASA_OFF_DEFAULT_MASK) begin
        state_d.default_mask = reg_wdata;
      end else if (reg_addr == ASA_OFF_SF_MASK_AB) begin
        state_d.sf_mask_a = reg_wdata[7:0];
        state_d.sf_mask_b = reg_wdata[15:8];
      end else if (reg_addr == ASA_OFF_SF_MASK_C) begin
        state_d.sf_mask_c = reg_wdata[7:0];
      end else if (reg_addr == ASA_OFF_PF_MASK_AB) begin
        state_d.pf_mask_a = reg_wdata[7:0];
        state_d.pf_mask_b = reg_wdata[15:8];
      end else if (reg_addr == ASA_OFF_PF_MASK_CD) begin
        state_d.pf_mask_c = reg_wdata[7:0];
        state_d.pf_mask_d = reg_wdata[15:8];
      end else if (reg_addr == ASA_OFF_IRQ_MASK) begin
        state_d.irq_mask = reg_wdata;
      end else if (reg_addr == ASA_OFF_CONTROL) begin
        state_d.cfg_mode = reg_wdata[ASA_B_CFG];
        if (state_q.cfg_mode && !reg_wdata[ASA_B_CFG]) begin
          state_d.alarm_enable = state_q.default_mask;
        end
      end
    end
    // Latched raw events and sticky status; set wins over clear
    state_d.raw_events = (state_q.raw_events & ~clr) | ev;
    // Reserved bit 8 stays clear: raw word never sets it and clear only drops bits
    state_d.sticky = (state_q.sticky & ~clr) | (raw_word & state_q.alarm_enable);
    // Read mux
    if (reg_addr == ASA_OFF_ALARM_STATUS) begin
      rd_val = state_q.sticky;
    end else if (reg_addr == ASA_OFF_RAW_STATUS) begin
      rd_val = raw_word;
    end else if (reg_addr == ASA_OFF_ALARM_ENABLE) begin
      rd_val = state_q.alarm_enable;
    end else if (reg_addr == ASA_OFF_DEFAULT_MASK) begin
      rd_val = state_q.default_mask;
    end else if (reg_addr == ASA_OFF_SF_MASK_AB) begin
      rd_val = {state_q.sf_mask_b, state_q.sf_mask_a};
    end else if (reg_addr == ASA_OFF_SF_MASK_C) begin
      rd_val = {ASA_ZERO8, state_q.sf_mask_c};
    end else if (reg_addr == ASA_OFF_PF_MASK_AB) begin
      rd_val = {state_q.pf_mask_b, state_q.pf_mask_a};
    end else if (reg_addr == ASA_OFF_PF_MASK_CD) begin
      rd_val = {state_q.pf_mask_d, state_q.pf_mask_c};
    end else if (reg_addr == ASA_OFF_IRQ_MASK) begin
      rd_val = state_q.irq_mask;
    end else if (reg_addr == ASA_OFF_CONTROL) begin
      rd_val = {15'h0000, state_q.cfg_mode};
    end
    state_d.rdata = reg_rd ? rd_val : ASA_ZERO16;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q.default_mask <= ASA_DEFAULT_MASK_RST;
      state_q.alarm_enable <= ASA_DEFAULT_MASK_RST;
      state_q.sf_mask_a <= ASA_SF_MASK_A_RST;
      state_q.sf_mask_b <= ASA_SF_MASK_B_RST;
      state_q.sf_mask_c <= ASA_SF_MASK_C_RST;
      state_q.pf_mask_a <= ASA_PF_MASK_A_RST;
      state_q.pf_mask_b <= ASA_PF_MASK_B_RST;
      state_q.pf_mask_c <= ASA_PF_MASK_C_RST;
      state_q.pf_mask_d <= ASA_PF_MASK_D_RST;
      state_q.irq_mask <= ASA_IRQ_MASK_RST;
      state_q.sticky <= ASA_ZERO16;
      state_q.raw_events <= ASA_ZERO16;
      state_q.cfg_mode <= 1'b0;
      state_q.init <= ASA_INIT_IDLE;
      state_q.rdata <= ASA_ZERO16;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata = state_q.rdata;
  assign alarm_status = state_q.sticky;
  assign config_update_mode = state_q.cfg_mode;
  assign irq = |(state_q.sticky & state_q.irq_mask);

endmodule : asa_alarm_status_aggregator

// File: tb/asa_monitor.sv
// Assertion checker on the alarm status aggregator ports
`timescale 1ns/1ps
module asa_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [asa_pkg::ASA_ADDR_W-1:0] reg_addr,
  input wire logic [asa_pkg::ASA_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [asa_pkg::ASA_DATA_W-1:0] reg_rdata,
  // Sources
  input wire logic [7:0] safety_status_first,
  input wire logic [7:0] safety_status_second,
  input wire logic [7:0] safety_status_third,
  input wire logic wake_event,
  input wire logic charge_switch_off,
  input wire logic discharge_switch_off,
  input wire logic stack_below_shutdown,
  input wire logic fuse_driven,
  input wire logic balancing_active,
  // Results
  input wire logic [asa_pkg::ASA_DATA_W-1:0] alarm_status,
  input wire logic config_update_mode,
  input wire logic irq
);
  import asa_pkg::*;
  // ==========================================================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_raw_rd; reg_rd && reg_addr == ASA_OFF_RAW_STATUS; endsequence
  sequence s_wake_rd; wake_event ##1 !(reg_wr && reg_addr == ASA_OFF_ALARM_STATUS) ##1 s_raw_rd; endsequence
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rsvd; alarm_status[ASA_B_RSVD] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_safety_status_second_third_flag; s_raw_rd |=> reg_rdata[15] == $past(|{safety_status_second, safety_status_third}); endproperty
  a_safety_status_second_third_flag: assert property (p_safety_status_second_third_flag) else $error("raw bit 15 wrong");
  property p_ssa; s_raw_rd |=> reg_rdata[14] == $past(|safety_status_first); endproperty
  a_ssa: assert property (p_ssa) else $error("raw bit 14 wrong");
  property p_levels; s_raw_rd |=> reg_rdata[6:2] == $past({charge_switch_off, discharge_switch_off,
    stack_below_shutdown, fuse_driven, balancing_active}); endproperty
  a_levels: assert property (p_levels) else $error("raw level bits wrong");
  property p_wake; s_wake_rd |=> reg_rdata[ASA_B_WAKE]; endproperty
  a_wake: assert property (p_wake) else $error("wake bit missing");
  property p_irq; alarm_status == 16'h0000 |-> !irq; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without status");
  property p_cfg; reg_wr && reg_addr == ASA_OFF_CONTROL |=> config_update_mode == $past(reg_wdata[ASA_B_CFG]); endproperty
  a_cfg: assert property (p_cfg) else $error("config mode bit wrong");
endmodule : asa_monitor

// File: tb/asa_host_model.sv
// Host model speaking the register port
`timescale 1ns/1ps
module asa_host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [asa_pkg::ASA_ADDR_W-1:0] reg_addr,
  output logic [asa_pkg::ASA_DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [asa_pkg::ASA_DATA_W-1:0] reg_rdata
);
  import asa_pkg::*;
  // Idle bus at time zero
  initial begin
    reg_addr = 4'hF;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write, then address and data scrambled
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // One-cycle read, data taken mid-cycle while it stands
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
endmodule : asa_host_model

// File: tb/asa_alarm_status_aggregator_tb.sv
// Self-checking testbench for the alarm status aggregator
`timescale 1ns/1ps
module asa_alarm_status_aggregator_tb;
  import asa_pkg::*;
  logic ref_clk, rst, reg_wr, reg_rd, config_update_mode, irq;
  logic [3:0] reg_addr, ev;
  logic [4:0] lv;
  logic [15:0] reg_wdata, reg_rdata, alarm_status, rd_v;
  logic [79:0] w;
  logic [15:0] rst_tab [11] = '{16'h0000, 16'h0400, 16'hF800, 16'hF800, 16'hF7FC, 16'h00F4, 16'h9F5F, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
  int evb [4] = '{32'h0001, 32'h0202, 32'h0080, 32'h2000};
  int errors, n_tests, seed, lat, en, dm, st;
  // Clock of 40 ns period
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  asa_host_model u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  asa_alarm_status_aggregator u_asa_alarm_status_aggregator (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .safety_status_first(w[7:0]),
    .safety_status_second(w[15:8]), .safety_status_third(w[23:16]), .safety_alert_word_first(w[31:24]),
    .safety_alert_word_second(w[39:32]), .safety_alert_word_third(w[47:40]), .permanent_fault_triggered(ev[3]),
    .pf_alert_word_first(w[55:48]), .pf_alert_word_second(w[63:56]), .pf_alert_word_third(w[71:64]),
    .pf_alert_word_fourth(w[79:72]), .single_scan_done(ev[1]), .full_loop_done(ev[2]), .wake_event(ev[0]),
    .charge_switch_off(lv[4]), .discharge_switch_off(lv[3]), .stack_below_shutdown(lv[2]), .fuse_driven(lv[1]),
    .balancing_active(lv[0]), .alarm_status(alarm_status), .config_update_mode(config_update_mode), .irq(irq));
  // Reference raw word from latched events and live levels
  function automatic int exp_raw();
    int r;
    r = lat | (int'(lv) << 2) | (int'(|w[23:8]) << 15) | (int'(|w[7:0]) << 14);
    r |= int'(|{w[31:24] & ASA_SF_MASK_A_RST, w[39:32] & ASA_SF_MASK_B_RST, w[47:40] & ASA_SF_MASK_C_RST}) << 12;
    return r | (int'(|{w[55:48] & ASA_PF_MASK_A_RST, w[63:56] & ASA_PF_MASK_B_RST}) << 11);
  endfunction : exp_raw
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Verdict and end of run
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    test_done();
  end
  // Main sequence
  initial begin
    seed = 32'h56ff;
    errors = 0;
    n_tests = 0;
    rst = 1'b1;
    w = '0;
    ev = 4'h0;
    lv = 5'h00;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    lat = 32'h0400;
    st = 0;
    for (int i = 0; i < 11; i++) begin
      u_host.rd(i == 10 ? 4'hF : 4'(i), rd_v);
      chk(rd_v, rst_tab[i]);
    end
    $display("test reset values done");
    dm = $random(seed);
    u_host.wr(ASA_OFF_DEFAULT_MASK, dm[15:0]);
    u_host.wr(ASA_OFF_RAW_STATUS, 16'hFFFF);
    u_host.wr(ASA_OFF_CONTROL, 16'h0001);
    u_host.wr(ASA_OFF_ALARM_ENABLE, 16'h0001);
    u_host.wr(ASA_OFF_CONTROL, 16'h0000);
    u_host.rd(ASA_OFF_ALARM_ENABLE, rd_v);
    chk(rd_v, dm[15:0]);
    en = dm;
    $display("test default reload done");
    repeat (40) begin
      @(posedge ref_clk);
      for (int k = 0; k < 10; k++) w[k*8 +: 8] <= 8'($random(seed) & $random(seed) & $random(seed));
      lv <= 5'($random(seed));
      @(posedge ref_clk);
      st |= exp_raw() & en & 32'hFEFF;
      u_host.rd(ASA_OFF_RAW_STATUS, rd_v);
      chk(rd_v, 16'(exp_raw()));
      chk(alarm_status, 16'(st));
    end
    $display("test levels done");
    u_host.wr(ASA_OFF_IRQ_MASK, 16'hFFFF);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      ev[k] <= 1'b1;
      @(posedge ref_clk);
      ev[k] <= 1'b0;
      u_host.rd(ASA_OFF_RAW_STATUS, rd_v);
      lat |= evb[k];
      st |= exp_raw() & en & 32'hFEFF;
      chk(rd_v, 16'(exp_raw()));
      chk(alarm_status, 16'(st));
    end
    chk({15'h0000, irq}, {15'h0000, st != 0});
    u_host.wr(ASA_OFF_IRQ_MASK, 16'h0000);
    @(negedge ref_clk);
    chk({15'h0000, irq}, 16'h0000);
    @(posedge ref_clk);
    w <= '0;
    lv <= 5'h00;
    // Second clear: latched events still set the sticky word at the first clear edge
    u_host.wr(ASA_OFF_ALARM_STATUS, 16'hFFFF);
    u_host.wr(ASA_OFF_ALARM_STATUS, 16'hFFFF);
    lat = 0;
    u_host.rd(ASA_OFF_RAW_STATUS, rd_v);
    chk(rd_v, 16'h0000);
    chk(alarm_status, 16'h0000);
    $display("test events and interrupt done");
    test_done();
  end
endmodule : asa_alarm_status_aggregator_tb
bind asa_alarm_status_aggregator asa_monitor u_asa_monitor (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .safety_status_first(safety_status_first), .safety_status_second(safety_status_second),
  .safety_status_third(safety_status_third), .wake_event(wake_event), .charge_switch_off(charge_switch_off),
  .discharge_switch_off(discharge_switch_off), .stack_below_shutdown(stack_below_shutdown),
  .fuse_driven(fuse_driven), .balancing_active(balancing_active), .alarm_status(alarm_status),
  .config_update_mode(config_update_mode), .irq(irq));
